// *** core/ahp_pkg.sv ***
/*
  Shared constants for the converter host port: data width, buffer depth,
  control register field positions, register identity and reset values.
  Assumes nothing of its surroundings.
*/
package ahp_pkg;

  localparam int DATA_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;

  // Register identity field carried in every control word
  localparam int SEL_MSB = 11;
  localparam int SEL_LSB = 10;
  localparam logic [1:0] SEL_CTRL0 = 2'h0;
  localparam logic [1:0] SEL_CTRL1 = 2'h1;

  // Second control register fields
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_SYNC_RESET = 1;
  localparam int BIT_RW_MODE = 6;
  localparam int BIT_FORMAT = 7;
  localparam int BIT_OFFSET_CAL = 8;
  localparam int BIT_READBACK = 9;

  localparam logic [DATA_W-1:0] CTRL0_RESET = 12'h020;
  localparam logic [DATA_W-1:0] CTRL1_RESET = 12'h430;
  localparam logic [DATA_W-1:0] SOFT_RESET_MASK = 12'h001;

  // Two's complement to straight binary flips the sign bit
  localparam logic [DATA_W-1:0] SIGN_FLIP = 12'h800;

  typedef logic [DATA_W-1:0] ahp_word_type;

endpackage

// *** core/ahp_strobe_if.sv ***
/*
  Carrier between the pin front end and the register core: decoded strobe
  events, the captured write word and the strobe mode.
  Assumes both ends run on the same clock.
*/
interface ahp_strobe_if;
  import ahp_pkg::*;

  logic rw_mode;
  logic rd_active;
  logic rd_start;
  logic wr_done;
  ahp_word_type wr_word;

  modport front (input rw_mode, output rd_active, output rd_start, output wr_done, output wr_word);
  modport core (output rw_mode, input rd_active, input rd_start, input wr_done, input wr_word);
endinterface

// *** core/ahp_fifo.sv ***
/*
  Result buffer: synchronous FIFO with valid and ready on both sides.
  Assumes one clock; clear empties it in one cycle.
*/
module ahp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (clk_en && push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (clk_en)
    begin
      if (clear)
      begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end
      else
      begin
        if (push)
        begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop)
        begin
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
    end
  end
endmodule

// *** core/ahp_strobe.sv ***
/*
  Pin front end: synchronises chip selects, strobes and data, forms the
  internal read and write strobes and reports their edges.
  Assumes the pins are asynchronous to ref_clk.
*/
module ahp_strobe (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire ahp_pkg::ahp_word_type data_in,
  ahp_strobe_if.front bus
);
  import ahp_pkg::*;

  localparam int PINS = DATA_W + 4;

  logic [PINS-1:0] meta;
  logic [PINS-1:0] pin;
  logic read_req;
  logic write_req;
  logic selected;
  logic rd_int;
  logic wr_int;
  logic rd_prev;
  logic wr_prev;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= {4'hf, {DATA_W{1'b0}}};
      pin <= {4'hf, {DATA_W{1'b0}}};
    end
    else if (clk_en)
    begin
      meta <= {chip_select_low_n, !chip_select_high, rd_n, wr_n, data_in};
      pin <= meta;
    end
  end

  // Combined mode: wr_n high means read, low means write; rd_n ignored
  assign selected = !pin[DATA_W+3] && !pin[DATA_W+2];
  assign read_req = bus.rw_mode ? pin[DATA_W] : !pin[DATA_W+1];
  assign write_req = !pin[DATA_W];
  assign rd_int = selected && read_req && !write_req;
  assign wr_int = selected && write_req && !(bus.rw_mode ? 1'b0 : !pin[DATA_W+1]);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      bus.wr_word <= '0;
    end
    else if (clk_en)
    begin
      rd_prev <= rd_int;
      wr_prev <= wr_int;
      if (wr_int)
      begin
        bus.wr_word <= pin[DATA_W-1:0];
      end
    end
  end

  assign bus.rd_active = rd_int;
  assign bus.rd_start = rd_int && !rd_prev;
  assign bus.wr_done = wr_prev && !wr_int;
endmodule

// *** core/ahp_port.sv ***
/*
  Host port of a two-input sampling converter: control registers zero and
  one, strobe decoding, offset correction, number format and a result FIFO
  read by the host, with debug readback of both control registers.
  Assumes conversion results arrive on ref_clk with valid and ready, and
  that the host pins are asynchronous to ref_clk.
*/
// Function
// [RQ1] Soft reset bit holds registers at reset
// [RQ2] Bit one pulses sync generator reset
// [RQ3] Host writes zero to reserved bits
// [RQ4] Bit six selects combined or separate strobes
// [RQ5] Bit seven selects binary or twos complement
// [RQ6] Bit eight calibrates and subtracts stored offset
// [RQ7] Debug readback returns register zero, then one
// [RQ8] Host clears bit nine to leave debug
// [RQ9] Internal read strobe drives data and drivers
// [RQ10] Read strobe follows last valid, first invalid
// [RQ11] Write strobe needs selects, write, no read
// [RQ12] Register one identified by bits 11:10 = 01
// [RQ13] New control value applies after strobe release
module ahp_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire ahp_pkg::ahp_word_type data_in,
  output ahp_pkg::ahp_word_type data_out,
  output logic data_oe,
  output logic conversion_data_available,
  input wire logic conv_valid,
  input wire ahp_pkg::ahp_word_type conv_data,
  output logic conv_ready,
  output logic force_zero_input,
  output logic device_reset,
  output logic sync_gen_reset,
  output ahp_pkg::ahp_word_type control_register_zero,
  output ahp_pkg::ahp_word_type control_register_one
);
  import ahp_pkg::*;

  function automatic ahp_word_type apply_format(input ahp_word_type value, input logic binary);
    apply_format = binary ? (value ^ SIGN_FLIP) : value;
  endfunction

  ahp_strobe_if bus ();

  ahp_word_type offset;
  ahp_word_type stage_data;
  ahp_word_type fifo_out_data;
  logic stage_valid;
  logic next_stage_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic accept;
  logic write_one;
  logic write_zero;
  logic debug_mode;
  logic readback_second;

  //////////////////////////////////////////////////////////////////////////////
  // Pin front end

  ahp_strobe u_strobe (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .chip_select_low_n(chip_select_low_n),
    .chip_select_high(chip_select_high),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .data_in(data_in),
    .bus(bus)
  );

  assign bus.rw_mode = control_register_one[BIT_RW_MODE]; // [RQ4]
  assign debug_mode = control_register_one[BIT_READBACK];
  assign device_reset = control_register_one[BIT_SOFT_RESET];

  //////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Words are committed when the write strobe releases
  assign write_one = bus.wr_done && (bus.wr_word[SEL_MSB:SEL_LSB] == SEL_CTRL1); // [RQ12] [RQ13]
  assign write_zero = bus.wr_done && (bus.wr_word[SEL_MSB:SEL_LSB] == SEL_CTRL0);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      control_register_zero <= CTRL0_RESET;
      control_register_one <= CTRL1_RESET;
    end
    else if (clk_en)
    begin
      if (write_one && bus.wr_word[BIT_SOFT_RESET])
      begin
        control_register_zero <= CTRL0_RESET; // [RQ1]
        control_register_one <= CTRL1_RESET | SOFT_RESET_MASK; // [RQ1]
      end
      else if (write_one)
      begin
        control_register_one <= bus.wr_word; // [RQ11] [RQ8]
      end
      else if (write_zero && !device_reset)
      begin
        control_register_zero <= bus.wr_word; // [RQ11]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_gen_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_gen_reset <= write_one && bus.wr_word[BIT_SYNC_RESET]; // [RQ2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Offset calibration: the next result with inputs forced to zero is kept

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      force_zero_input <= 1'b0;
      offset <= '0;
    end
    else if (clk_en)
    begin
      if (write_one)
      begin
        force_zero_input <= bus.wr_word[BIT_OFFSET_CAL] && !bus.wr_word[BIT_SOFT_RESET]; // [RQ6]
      end
      else if (accept && force_zero_input)
      begin
        force_zero_input <= 1'b0;
        offset <= conv_data; // [RQ6]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result stage: correction and format, then into the FIFO

  assign accept = conv_valid && conv_ready;

  always_comb
  begin
    next_stage_valid = stage_valid && !fifo_in_ready;
    if (accept && !force_zero_input && !device_reset)
    begin
      next_stage_valid = 1'b1;
    end
    if (device_reset)
    begin
      next_stage_valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage_valid <= 1'b0;
      stage_data <= '0;
      conv_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      stage_valid <= next_stage_valid;
      conv_ready <= !next_stage_valid;
      if (accept && !force_zero_input)
      begin
        stage_data <= apply_format(conv_data - offset, control_register_one[BIT_FORMAT]); // [RQ5] [RQ6]
      end
    end
  end

  ahp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .clear(device_reset),
    .in_valid(stage_valid),
    .in_ready(fifo_in_ready),
    .in_data(stage_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Host reads

  assign fifo_pop = bus.rd_start && !debug_mode && !device_reset;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= '0;
      data_oe <= 1'b0;
      readback_second <= 1'b0;
      conversion_data_available <= 1'b0;
    end
    else if (clk_en)
    begin
      data_oe <= bus.rd_active; // [RQ9] [RQ10]
      conversion_data_available <= fifo_out_valid;
      if (write_one)
      begin
        readback_second <= 1'b0;
      end
      else if (bus.rd_start && debug_mode)
      begin
        readback_second <= !readback_second;
      end
      if (bus.rd_start && debug_mode)
      begin
        data_out <= readback_second ? control_register_one : control_register_zero; // [RQ7]
      end
      else if (fifo_pop && fifo_out_valid)
      begin
        data_out <= fifo_out_data; // [RQ9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_write_one;
    clk_en && write_one;
  endsequence

  sequence s_debug_read;
    clk_en && bus.rd_start && debug_mode;
  endsequence

  sequence s_fifo_read;
    clk_en && fifo_pop && fifo_out_valid;
  endsequence

  // Soft reset seen on an enabled edge, then one more enabled edge
  sequence s_reset_flush;
    clk_en && device_reset ##1 clk_en;
  endsequence

  a_soft_reset_load: assert property ((s_write_one and bus.wr_word[BIT_SOFT_RESET]) // [RQ1]
    |=> device_reset && control_register_zero == CTRL0_RESET)
    else $error("soft reset did not reload registers");
  a_soft_reset_hold: assert property (clk_en && device_reset && !write_one |=> device_reset) // [RQ1]
    else $error("soft reset left without a write");
  a_reset_flush: assert property (s_reset_flush |=> !conversion_data_available) // [RQ1]
    else $error("results kept through soft reset");
  a_zero_guard: assert property (clk_en && write_zero && device_reset |=> $stable(control_register_zero)) // [RQ1]
    else $error("register zero written during soft reset");
  a_sync_pulse: assert property ((s_write_one and !bus.wr_word[BIT_SOFT_RESET]) // [RQ2]
    ##0 bus.wr_word[BIT_SYNC_RESET] |=> sync_gen_reset && control_register_one[BIT_SYNC_RESET])
    else $error("sync generator reset not pulsed");
  a_sync_single: assert property (clk_en && sync_gen_reset && !write_one |=> !sync_gen_reset) // [RQ2]
    else $error("sync generator reset longer than one cycle");
  a_mode_follow: assert property ((s_write_one and !bus.wr_word[BIT_SOFT_RESET]) // [RQ4]
    |=> bus.rw_mode == $past(bus.wr_word[BIT_RW_MODE]))
    else $error("strobe mode not taken");
  a_result_format: assert property (clk_en && accept && !force_zero_input && !device_reset // [RQ5] [RQ6]
    |=> stage_valid && stage_data == apply_format($past(conv_data) - $past(offset),
    $past(control_register_one[BIT_FORMAT])))
    else $error("result not corrected or formatted");
  a_cal_store: assert property (clk_en && accept && force_zero_input && !write_one // [RQ6]
    |=> offset == $past(conv_data) && !force_zero_input)
    else $error("calibration result not stored");
  a_cal_drop: assert property (clk_en && accept && force_zero_input |=> !stage_valid) // [RQ6]
    else $error("calibration result forwarded");
  a_readback_order: assert property ((s_debug_read and !readback_second && !write_one) // [RQ7]
    |=> data_out == $past(control_register_zero))
    else $error("first debug read not register zero");
  a_readback_second: assert property ((s_debug_read and readback_second && !write_one) // [RQ7]
    |=> data_out == $past(control_register_one))
    else $error("second debug read not register one");
  a_read_pop: assert property (s_fifo_read |=> data_out == $past(fifo_out_data)) // [RQ9]
    else $error("popped result not presented");
  a_oe_tracks: assert property (clk_en |=> data_oe == $past(bus.rd_active)) // [RQ9] [RQ10]
    else $error("driver enable does not follow read strobe");
  a_strobe_excl: assert property (bus.rd_start |-> !bus.wr_done) // [RQ11]
    else $error("read and write strobes overlap");
  a_commit_release: assert property (clk_en && !write_one && !write_zero // [RQ13]
    |=> $stable(control_register_one) && $stable(control_register_zero))
    else $error("register changed without strobe release");
endmodule

// *** tb/ahp_host.sv ***
/*
  Host bus master model: drives chip selects, strobes and control words,
  in separate or combined strobe mode, and samples the read word.
  Assumes its tasks are called from the falling edge of ref_clk.
*/
module ahp_host (
  input wire logic ref_clk,
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic rd_n,
  output logic wr_n,
  output ahp_pkg::ahp_word_type data_in,
  input wire ahp_pkg::ahp_word_type data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import ahp_pkg::*;

  logic comb = 1'b0;
  int slow = 0;

  initial
  begin
    {chip_select_low_n, chip_select_high, rd_n, wr_n} = 4'hb;
    data_in = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe leads the chip selects; bus word inverted once hold has passed
  task automatic access(input logic rd, input logic clash, input ahp_word_type w,
                        output ahp_word_type got, output logic oe);
    ahp_word_type v;
    v = (w[SEL_MSB:SEL_LSB] == SEL_CTRL1) ? (w & 12'hfc3) : w;
    @(negedge ref_clk);
    data_in = rd ? data_in : v;
    wr_n = rd & !clash;
    rd_n = comb | (!rd & !clash);
    @(negedge ref_clk);
    {chip_select_low_n, chip_select_high} = 2'b01;
    repeat (5 + slow) @(negedge ref_clk);
    got = data_out;
    oe = data_oe;
    {chip_select_low_n, chip_select_high, rd_n, wr_n} = 4'hb;
    repeat (4) @(negedge ref_clk);
    if (!rd)
      data_in = ~v;
    if (!rd && !clash && v[SEL_MSB:SEL_LSB] == SEL_CTRL1)
      comb = v[BIT_RW_MODE] & !v[BIT_SOFT_RESET];
  endtask
endmodule

// *** tb/ahp_port_bench.sv ***
/*
  Self-checking bench for the converter host port.
  Assumes the host model on the pins and a converter stream driven here.
*/
module ahp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ahp_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cv = 1'b0;
  logic cs_n, cs_h, rd_n, wr_n, oe, avail, cr, fz, dres, sres, ok;
  ahp_word_type cd = 12'h000;
  ahp_word_type din, dout, r0, r1;
  int n_fail = 0;
  int cmp_count = 0;
  int syncs = 0;

  ahp_port dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .chip_select_low_n(cs_n),
    .chip_select_high(cs_h), .rd_n(rd_n), .wr_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe(oe), .conversion_data_available(avail), .conv_valid(cv), .conv_data(cd),
    .conv_ready(cr), .force_zero_input(fz), .device_reset(dres), .sync_gen_reset(sres),
    .control_register_zero(r0), .control_register_one(r1));
  ahp_host host_u (.ref_clk(ref_clk), .chip_select_low_n(cs_n), .chip_select_high(cs_h),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(din), .data_out(dout), .data_oe(oe));

  initial
    forever #5 ref_clk = ~ref_clk;

  always @(negedge ref_clk)
    if (sres === 1'b1)
      syncs++;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input ahp_word_type seen, input ahp_word_type exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wr(input ahp_word_type w);
    ahp_word_type g;
    logic o;
    host_u.access(1'b0, 1'b0, w, g, o);
  endtask

  task automatic rd(input string s, input ahp_word_type exp);
    ahp_word_type g;
    logic o;
    host_u.access(1'b1, 1'b0, 12'h000, g, o);
    chk(s, g, exp);
    chk("oe on", {11'h0, o}, 12'h001);
    chk("oe off", {11'h0, oe}, 12'h000);
  endtask

  // Result offered until taken or 30 cycles pass; data inverted after
  task automatic push(input ahp_word_type v, output logic acc);
    int k;
    @(negedge ref_clk);
    cd = v;
    cv = 1'b1;
    for (k = 0; k < 30 && cr !== 1'b1; k++)
      @(negedge ref_clk);
    if (k < 30)
      @(negedge ref_clk);
    cv = 1'b0;
    cd = ~v;
    acc = (k < 30);
    repeat (3) @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    ahp_word_type g;
    logic o;
    chk("r0 reset", r0, 12'h020);
    chk("r1 reset", r1, 12'h430);
    chk("dres reset", {11'h0, dres}, 12'h000);
    chk("ready reset", {11'h0, cr}, 12'h001);
    wr(12'h3a5);
    chk("r0 wr", r0, 12'h3a5);
    wr(12'h8ff);
    chk("r0 sel", r0, 12'h3a5);
    chk("r1 sel", r1, 12'h430);
    host_u.access(1'b0, 1'b1, 12'h0ff, g, o);
    chk("r0 clash", r0, 12'h3a5);
    chk("oe clash", {11'h0, o}, 12'h000);
    $display("test regs done");
  endtask

  task automatic t_fmt();
    int n;
    wr(12'h480);
    chk("r1 wr", r1, 12'h480);
    push(12'h123, ok);
    chk("avail", {11'h0, avail}, 12'h001);
    rd("binary", 12'h923);
    wr(12'h400);
    push(12'h123, ok);
    rd("twos", 12'h123);
    n = syncs;
    wr(12'h402);
    chk("sync", 12'(syncs - n), 12'h001);
    $display("test format done");
  endtask

  task automatic t_soft();
    wr(12'h401);
    chk("dres", {11'h0, dres}, 12'h001);
    chk("r0 soft", r0, 12'h020);
    chk("r1 soft", r1, 12'h431);
    wr(12'h155);
    chk("r0 held", r0, 12'h020);
    wr(12'h400);
    chk("dres off", {11'h0, dres}, 12'h000);
    chk("r1 out", r1, 12'h400);
    $display("test soft reset done");
  endtask

  task automatic t_dbg();
    wr(12'h1c3);
    wr(12'h600);
    push(12'h077, ok);
    rd("dbg r0", 12'h1c3);
    rd("dbg r1", 12'h600);
    wr(12'h400);
    rd("normal", 12'h077);
    $display("test debug done");
  endtask

  task automatic t_comb();
    wr(12'h440);
    host_u.slow = 3;
    wr(12'h2aa);
    chk("r0 comb", r0, 12'h2aa);
    push(12'h0c4, ok);
    rd("comb rd", 12'h0c4);
    wr(12'h400);
    host_u.slow = 0;
    $display("test combined done");
  endtask

  task automatic t_cal();
    wr(12'h500);
    chk("fz on", {11'h0, fz}, 12'h001);
    push(12'h010, ok);
    chk("fz off", {11'h0, fz}, 12'h000);
    chk("cal kept", {11'h0, avail}, 12'h000);
    push(12'h110, ok);
    rd("offset", 12'h100);
    $display("test calibration done");
  endtask

  // Host stalls while the buffer fills, then drains it in order
  task automatic t_fifo();
    int n;
    n = 0;
    for (int i = 0; i < 20; i++)
    begin
      push(12'(12'h020 + i), ok);
      n += ok;
    end
    chk("refused", {11'h0, n >= FIFO_DEPTH && n < 20}, 12'h001);
    chk("ready full", {11'h0, cr}, 12'h000);
    for (int i = 0; i < n; i++)
      rd("drain", 12'(12'h010 + i));
    chk("empty", {11'h0, avail}, 12'h000);
    $display("test fifo done");
  endtask

  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_regs();
    t_fmt();
    t_soft();
    t_dbg();
    t_comb();
    t_cal();
    t_fifo();
    results();
  end

  initial
  begin
    #200us;
    n_fail++;
    results();
  end
endmodule
